// ### bench/test_timer_counter_input_capture.sv
// Self-checking bench of the two-channel timer with input capture.
`timescale 1ns/1ps
module test_timer_counter_input_capture;
  import tmric_pkg::*;
  logic ref_clk;
  logic rst_n;
  logic psel;
  logic penable;
  logic [11:0] paddr;
  logic pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic external_timer_clock_pin;
  logic [1:0] chan_pin;
  logic timer_irq;
  logic [31:0] rd;
  logic err;
  int fail_count;
  int num_checks;
  int cyc;

  tmric_timer tmric_timer_i (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .paddr(paddr), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_timer_clock_pin(external_timer_clock_pin), .chan_pin(chan_pin),
    .timer_irq(timer_irq));

  tmric_pin_source tmric_pin_source_i (.ref_clk(ref_clk), .chan_pin(chan_pin),
    .external_timer_clock_pin(external_timer_clock_pin));

  // ==========================================================================
  // Clock, timeout and verdict
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (fail_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // ==========================================================================
  // Bus tasks
  // The request is held until pready is seen high at a rising edge; data is taken there.
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= {idx, 2'b00};
    pwrite <= wr;
    pwdata <= {24'h0, wd};
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd16(input logic [9:0] hi, output logic [15:0] v);
    apb(1'b0, hi, 8'h00);
    v[15:8] = rd[7:0];
    apb(1'b0, hi + 10'h001, 8'h00);
    v[7:0] = rd[7:0];
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_regs();
    logic [15:0] v;
    apb(1'b0, IDX_TSC, 8'h00);
    check("status reset", rd[15:0], 16'h0020);
    apb(1'b0, IDX_MODH, 8'h00);
    check("modulo high reset", rd[15:0], 16'h00ff);
    apb(1'b1, IDX_CNTL, 8'h5a);
    apb(1'b0, IDX_CNTL, 8'h00);
    check("count low halted", rd[15:0], 16'h0000);
    apb(1'b0, 10'h04b, 8'h00);
    check("unmapped error", {15'h0, err}, 16'h0001);
    check("unmapped data", rd[15:0], 16'h0000);
    apb(1'b1, IDX_TSC, 8'hff);
    apb(1'b0, IDX_TSC, 8'h00);
    check("status fields", rd[15:0], 16'h0067);
    apb(1'b1, IDX_CH0SC, 8'h7f);
    apb(1'b0, IDX_CH0SC, 8'h00);
    check("chan0 fields", rd[15:0], 16'h007f);
    apb(1'b1, IDX_CH1SC, 8'hff);
    apb(1'b0, IDX_CH1SC, 8'h00);
    check("chan1 fields", rd[15:0], 16'h005f);
    apb(1'b1, IDX_CH1H, 8'h12);
    apb(1'b1, IDX_CH1L, 8'h34);
    rd16(IDX_CH1H, v);
    check("chan1 value", v, 16'h1234);
  endtask

  task automatic t_rates();
    logic [7:0] a;
    // The first and last counter reads are 64 cycles apart, so every divided rate fits.
    for (int ps = 0; ps < 7; ps++) begin
      apb(1'b1, IDX_TSC, 8'h10 | ps[7:0]);
      apb(1'b0, IDX_CNTL, 8'h00);
      a = rd[7:0];
      apb(1'b0, IDX_CNTL, 8'h00);
      repeat (56) @(posedge ref_clk);
      apb(1'b0, IDX_CNTL, 8'h00);
      check("count advance", {8'h0, rd[7:0] - a}, 16'h0040 >> ps);
    end
    apb(1'b1, IDX_TSC, 8'h17);
    tmric_pin_source_i.ext_ticks(5);
    repeat (8) @(posedge ref_clk);
    apb(1'b0, IDX_CNTL, 8'h00);
    check("pin clock count", rd[15:0], 16'h0005);
    apb(1'b0, IDX_CNTH, 8'h00);
    check("count high", rd[15:0], 16'h0000);
  endtask

  task automatic t_overflow();
    logic [7:0] a;
    apb(1'b1, IDX_MODH, 8'h00);
    apb(1'b1, IDX_MODL, 8'h03);
    apb(1'b1, IDX_TSC, 8'h50);
    apb(1'b0, IDX_CNTL, 8'h00);
    a = rd[7:0];
    apb(1'b0, IDX_CNTL, 8'h00);
    check("modulo period", rd[15:0], {8'h0, a});
    check("count in range", {15'h0, a <= 8'h03}, 16'h0001);
    apb(1'b0, IDX_TSC, 8'h00);
    check("overflow flag", rd[15:0], 16'h00c0);
    check("overflow irq", {15'h0, timer_irq}, 16'h0001);
    apb(1'b1, IDX_TSC, 8'he0);
    apb(1'b1, IDX_TSC, 8'h60);
    apb(1'b0, IDX_TSC, 8'h00);
    check("overflow cleared", rd[15:0], 16'h0060);
    check("irq dropped", {15'h0, timer_irq}, 16'h0000);
    apb(1'b1, IDX_MODH, 8'hff);
    apb(1'b1, IDX_MODL, 8'hff);
  endtask

  task automatic t_capture();
    logic [15:0] v0;
    logic [15:0] v1;
    logic [15:0] keep;
    int t0;
    int t1;
    apb(1'b1, IDX_TSC, 8'h10);
    // Channel 0 takes the rise, channel 1 the edge that its code selects.
    for (int c = 1; c < 4; c++) begin
      apb(1'b1, IDX_CH0SC, 8'h44);
      apb(1'b1, IDX_CH1SC, {4'h0, c[1:0], 2'h0});
      tmric_pin_source_i.pulse(2'h3, 10, t0);
      repeat (6) @(posedge ref_clk);
      rd16(IDX_CH0H, v0);
      rd16(IDX_CH1H, v1);
      check("edge spacing", v1 - v0, (c == 1) ? 16'h0000 : 16'h000a);
      apb(1'b0, IDX_CH1SC, 8'h00);
      check("chan1 flag", rd[15:0], {8'h0, 4'h8, c[1:0], 2'h0});
      apb(1'b0, IDX_CH0SC, 8'h00);
      check("chan0 flag", rd[15:0], 16'h00c4);
      check("capture irq", {15'h0, timer_irq}, 16'h0001);
    end
    tmric_pin_source_i.pulse(2'h1, 4, t1);
    repeat (6) @(posedge ref_clk);
    rd16(IDX_CH0H, keep);
    check("overwrite", keep - v0, 16'(t1 - t0));
    apb(1'b1, IDX_CH1SC, 8'h00);
    apb(1'b1, IDX_CH0SC, 8'h04);
    tmric_pin_source_i.pulse(2'h3, 4, t0);
    repeat (6) @(posedge ref_clk);
    rd16(IDX_CH1H, keep);
    check("edge off value", keep, v1);
    apb(1'b0, IDX_CH1SC, 8'h00);
    check("edge off flag", rd[15:0], 16'h0000);
    check("irq masked", {15'h0, timer_irq}, 16'h0000);
    apb(1'b1, IDX_CH0SC, 8'h24);
    apb(1'b1, IDX_CH1SC, 8'h04);
    tmric_pin_source_i.pulse(2'h3, 4, t0);
    repeat (6) @(posedge ref_clk);
    apb(1'b0, IDX_CH1SC, 8'h00);
    check("linked chan1 idle", rd[15:0], 16'h0004);
    rd16(IDX_CH0H, v0);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd16(IDX_CH0H, keep);
    check("value over reset", keep, v0);
    apb(1'b0, IDX_TSC, 8'h00);
    check("status after reset", rd[15:0], 16'h0020);
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    paddr = 12'h000;
    pwrite = 1'b0;
    pwdata = 32'h0;
    fail_count = 0;
    num_checks = 0;
    cyc = 0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_regs();
    t_rates();
    t_overflow();
    t_capture();
    stop_test();
  end
endmodule

// ### bench/tmric_pin_source.sv
// Signal sources standing on the capture pins and the timer clock pin.
`timescale 1ns/1ps
module tmric_pin_source (
  // Clock.
  input wire logic ref_clk,
  // Pins.
  output logic [1:0] chan_pin,
  output logic external_timer_clock_pin
);
  int cyc;

  initial begin
    chan_pin = 2'h0;
    external_timer_clock_pin = 1'b0;
    cyc = 0;
  end

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
  end

  // ==========================================================================
  // Pulse tasks
  // Raises the chosen pins for width cycles and reports the cycle of the rise.
  task automatic pulse(input logic [1:0] mask, input int width, output int t_rise);
    @(posedge ref_clk);
    chan_pin <= mask;
    t_rise = cyc;
    repeat (width) @(posedge ref_clk);
    chan_pin <= 2'h0;
  endtask

  // Clock bursts just below the pin rate limit; the pin rests low between them.
  task automatic ext_ticks(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      external_timer_clock_pin <= 1'b1;
      repeat (32) @(posedge ref_clk);
      external_timer_clock_pin <= 1'b0;
      repeat (31) @(posedge ref_clk);
    end
  endtask
endmodule

// ### design/tmric_cap_edge.sv
// Pin synchroniser and programmable edge detector of one capture channel.
`timescale 1ns/1ps
module tmric_cap_edge
  import tmric_pkg::*;
(
  // Clock and reset.
  input logic ref_clk,
  input logic rst_n,
  // Channel pin and selection.
  input logic pin,
  input logic [1:0] edge_sel,
  input logic enable,
  // Capture strobe.
  output logic capture
);

  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic rise;
  logic fall;

  // ==========================================================================
  // Synchroniser; the third stage only serves edge detection.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  assign rise = s2_r && !s3_r;
  assign fall = !s2_r && s3_r;

  // ==========================================================================
  // Edge qualification.
  always_comb begin
    capture = 1'b0;
    if (enable) begin
      case (edge_sel)
        EDGE_RISE: capture = rise;
        EDGE_FALL: capture = fall;
        EDGE_ANY: capture = rise || fall;
        default: capture = 1'b0;
      endcase
    end
  end

endmodule

// ### design/tmric_pkg.sv
// Shared constants and field layouts of the timer with input capture.
package tmric_pkg;

  // ==========================================================================
  // Register indices (byte address is four times the index).
  localparam logic [9:0] IDX_TSC = 10'h040;
  localparam logic [9:0] IDX_CNTH = 10'h041;
  localparam logic [9:0] IDX_CNTL = 10'h042;
  localparam logic [9:0] IDX_MODH = 10'h043;
  localparam logic [9:0] IDX_MODL = 10'h044;
  localparam logic [9:0] IDX_CH0SC = 10'h045;
  localparam logic [9:0] IDX_CH0H = 10'h046;
  localparam logic [9:0] IDX_CH0L = 10'h047;
  localparam logic [9:0] IDX_CH1SC = 10'h048;
  localparam logic [9:0] IDX_CH1H = 10'h049;
  localparam logic [9:0] IDX_CH1L = 10'h04a;

  // ==========================================================================
  // Counter, prescaler and edge select encodings.
  localparam int DIV_W = 6;
  localparam logic [2:0] PS_EXT = 3'h7;
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_ANY = 2'h3;

  // ==========================================================================
  // Reset values.
  localparam logic [7:0] TSC_RESET = 8'h20;
  localparam logic [7:0] CHAN_RESET = 8'h00;
  localparam logic [15:0] MOD_RESET = 16'hffff;
  localparam logic [15:0] COUNT_RESET = 16'h0000;

  // ==========================================================================
  // Field layouts, bit 7 first.
  typedef struct packed {
    logic overflow_flag;
    logic overflow_irq_enable;
    logic counter_halt;
    logic counter_reset;
    logic zero_bit;
    logic [2:0] prescale_select;
  } tmric_tsc_type;

  typedef struct packed {
    logic chan_flag;
    logic chan_irq_enable;
    logic mode_sel_b;
    logic mode_sel_a;
    logic edge_level_sel_b;
    logic edge_level_sel_a;
    logic toggle_on_overflow;
    logic full_duty;
  } tmric_chan_ctl_type;

endpackage

// ### design/tmric_timer.sv
// Two-channel 16-bit timer with input capture behind an APB slave.
`timescale 1ns/1ps
// What this block does
// - One 16-bit up-counter, free-running or modulo, is the common time base.
// - The modulo register pair holds the terminal count of the counter.
// - Reading the counter bytes never disturbs or stalls the counting.
// - Each channel captures only with its mode bits at 00; other modes leave it idle.
// - Prescale select picks one of seven bus clock rates or the clock pin.
// - Status byte: overflow flag, irq enable, halt, reset, zero, prescale select.
// - Channel 0 byte: flag, irq enable, mode b, mode a, edge b, a, toggle, duty.
// - Channel 1 byte equals channel 0 layout but bit 5 reads zero.
// - Counter is shown as a high byte and a low byte.
// - Each channel value is two 8-bit registers making one 16-bit value.
// - An active pin edge copies the counter into the channel value registers.
// - Two edge select bits per channel choose the triggering transition.
// - Captured value is count before the edge plus two at the undivided rate, stored two cycles later.
// - Every qualifying edge overwrites the value even if the flag is set.
// - A capture sets the channel flag; with its enable set it requests an irq.
// - Capture triggers on rising only, falling only, or either edge.
// - The external timer clock works up to 4 MHz.
// - Reset leaves the channel value registers unchanged.
// - Channel 0 mode b links the pair and leaves channel 1 unused.
module tmric_timer
  import tmric_pkg::*;
(
  // Clock and reset.
  input logic ref_clk,
  input logic rst_n,
  // APB slave.
  input logic psel,
  input logic penable,
  input logic [11:0] paddr,
  input logic pwrite,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins.
  input logic external_timer_clock_pin,
  input logic [1:0] chan_pin,
  // Interrupt request.
  output logic timer_irq
);

  // ==========================================================================
  // State.
  tmric_tsc_type tsc_r;
  tmric_chan_ctl_type chan_ctl_r [2];
  logic [15:0] chan_val_r [2];
  logic [15:0] count_r;
  logic [15:0] mod_r;
  logic [DIV_W-1:0] div_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic irq_r;
  logic ext_s1_r;
  logic ext_s2_r;
  logic ext_s3_r;

  // ==========================================================================
  // Bus decode.
  logic [9:0] idx;
  logic mapped;
  logic access;
  logic rd_phase;
  logic wr_en;
  logic trst_wr;
  logic [7:0] wbyte;
  logic [7:0] rd_byte;
  tmric_tsc_type wtsc;
  tmric_chan_ctl_type wchan;

  assign idx = paddr[11:2];
  assign mapped = (paddr[1:0] == 2'h0) && (idx >= IDX_TSC) && (idx <= IDX_CH1L);
  assign access = psel && penable;
  assign rd_phase = access && !pready_r;
  assign wr_en = access && pready_r && pwrite && mapped;
  assign wbyte = pwdata[7:0];
  assign wtsc = tmric_tsc_type'(wbyte);
  assign wchan = tmric_chan_ctl_type'(wbyte);
  assign trst_wr = wr_en && (idx == IDX_TSC) && wtsc.counter_reset;

  // ==========================================================================
  // Clock pin synchroniser.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_s3_r <= 1'b0;
    end else begin
      ext_s1_r <= external_timer_clock_pin;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
    end
  end

  // ==========================================================================
  // Prescaler and counter tick.
  logic [DIV_W-1:0] div_mask;
  logic ext_rise;
  logic tick;
  logic wrap;

  assign ext_rise = ext_s2_r && !ext_s3_r;

  always_comb begin
    div_mask = DIV_W'((1 << tsc_r.prescale_select) - 1);
    tick = 1'b0;
    if (!tsc_r.counter_halt) begin
      if (tsc_r.prescale_select == PS_EXT) begin
        tick = ext_rise;
      end else begin
        tick = (div_r & div_mask) == div_mask;
      end
    end
  end

  assign wrap = tick && (count_r == mod_r);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      div_r <= '0;
    end else if (trst_wr) begin
      div_r <= '0;
    end else if (!tsc_r.counter_halt) begin
      div_r <= div_r + DIV_W'(1);
    end
  end

  // ==========================================================================
  // Counter.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      count_r <= COUNT_RESET;
    end else if (trst_wr) begin
      count_r <= COUNT_RESET;
    end else if (wrap) begin
      count_r <= COUNT_RESET;
    end else if (tick) begin
      count_r <= count_r + 16'h0001;
    end
  end

  // ==========================================================================
  // Modulo registers.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mod_r <= MOD_RESET;
    end else if (wr_en && idx == IDX_MODH) begin
      mod_r[15:8] <= wbyte;
    end else if (wr_en && idx == IDX_MODL) begin
      mod_r[7:0] <= wbyte;
    end
  end

  // ==========================================================================
  // Status and control; the reset and zero bits always read back as zero.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tsc_r <= tmric_tsc_type'(TSC_RESET);
    end else begin
      if (wr_en && idx == IDX_TSC) begin
        tsc_r.overflow_irq_enable <= wtsc.overflow_irq_enable;
        tsc_r.counter_halt <= wtsc.counter_halt;
        tsc_r.prescale_select <= wtsc.prescale_select;
        if (!wtsc.overflow_flag) begin
          tsc_r.overflow_flag <= 1'b0;
        end
      end
      if (wrap) begin
        tsc_r.overflow_flag <= 1'b1;
      end
      tsc_r.counter_reset <= 1'b0;
      tsc_r.zero_bit <= 1'b0;
    end
  end

  // ==========================================================================
  // Capture channels.
  logic [1:0] cap_pulse;
  logic [1:0] cap_en;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_chan
      localparam logic [9:0] SC_IDX = (gi == 0) ? IDX_CH0SC : IDX_CH1SC;
      localparam logic [9:0] VH_IDX = (gi == 0) ? IDX_CH0H : IDX_CH1H;
      localparam logic [9:0] VL_IDX = (gi == 0) ? IDX_CH0L : IDX_CH1L;

      // Capture mode is mode bits 00; a linked pair disables channel 1.
      assign cap_en[gi] = !chan_ctl_r[gi].mode_sel_b && !chan_ctl_r[gi].mode_sel_a &&
        ((gi == 0) || !chan_ctl_r[0].mode_sel_b);

      tmric_cap_edge u_edge (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .pin(chan_pin[gi]),
        .edge_sel({chan_ctl_r[gi].edge_level_sel_b, chan_ctl_r[gi].edge_level_sel_a}),
        .enable(cap_en[gi]),
        .capture(cap_pulse[gi])
      );

      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          chan_ctl_r[gi] <= tmric_chan_ctl_type'(CHAN_RESET);
        end else begin
          if (wr_en && idx == SC_IDX) begin
            chan_ctl_r[gi].chan_irq_enable <= wchan.chan_irq_enable;
            chan_ctl_r[gi].mode_sel_b <= (gi == 0) ? wchan.mode_sel_b : 1'b0;
            chan_ctl_r[gi].mode_sel_a <= wchan.mode_sel_a;
            chan_ctl_r[gi].edge_level_sel_b <= wchan.edge_level_sel_b;
            chan_ctl_r[gi].edge_level_sel_a <= wchan.edge_level_sel_a;
            chan_ctl_r[gi].toggle_on_overflow <= wchan.toggle_on_overflow;
            chan_ctl_r[gi].full_duty <= wchan.full_duty;
            if (!wchan.chan_flag) begin
              chan_ctl_r[gi].chan_flag <= 1'b0;
            end
          end
          if (cap_pulse[gi]) begin
            chan_ctl_r[gi].chan_flag <= 1'b1;
          end
        end
      end

      // Value registers keep their contents through reset.
      always_ff @(posedge ref_clk) begin
        if (cap_pulse[gi]) begin
          chan_val_r[gi] <= count_r;
        end else if (wr_en && idx == VH_IDX) begin
          chan_val_r[gi][15:8] <= wbyte;
        end else if (wr_en && idx == VL_IDX) begin
          chan_val_r[gi][7:0] <= wbyte;
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Read multiplexer.
  always_comb begin
    case (idx)
      IDX_TSC: rd_byte = tsc_r;
      IDX_CNTH: rd_byte = count_r[15:8];
      IDX_CNTL: rd_byte = count_r[7:0];
      IDX_MODH: rd_byte = mod_r[15:8];
      IDX_MODL: rd_byte = mod_r[7:0];
      IDX_CH0SC: rd_byte = chan_ctl_r[0];
      IDX_CH0H: rd_byte = chan_val_r[0][15:8];
      IDX_CH0L: rd_byte = chan_val_r[0][7:0];
      IDX_CH1SC: rd_byte = {chan_ctl_r[1][7:6], 1'b0, chan_ctl_r[1][4:0]};
      IDX_CH1H: rd_byte = chan_val_r[1][15:8];
      IDX_CH1L: rd_byte = chan_val_r[1][7:0];
      default: rd_byte = 8'h00;
    endcase
  end

  // ==========================================================================
  // APB answer: one wait state, data and error stand with pready.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= rd_phase;
      pslverr_r <= rd_phase && !mapped;
      if (rd_phase) begin
        prdata_r <= (mapped && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
    end
  end

  // ==========================================================================
  // Interrupt request.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= (tsc_r.overflow_flag && tsc_r.overflow_irq_enable) ||
        (chan_ctl_r[0].chan_flag && chan_ctl_r[0].chan_irq_enable) ||
        (chan_ctl_r[1].chan_flag && chan_ctl_r[1].chan_irq_enable);
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign timer_irq = irq_r;

  // ==========================================================================
  // Assertions.
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_wrap;
    wrap && !trst_wr;
  endsequence

  sequence s_step;
    tick && !wrap && !trst_wr;
  endsequence

  sequence s_rd_cnth;
    rd_phase && !pwrite && idx == IDX_CNTH ##1 pready_r;
  endsequence

  property p_wrap_zero;
    s_wrap |=> count_r == 16'h0000;
  endproperty
  a_wrap_zero: assert property (p_wrap_zero)
    else $error("Counter did not return to zero at the modulo value.");

  property p_wrap_flag;
    s_wrap |=> tsc_r.overflow_flag;
  endproperty
  a_wrap_flag: assert property (p_wrap_flag)
    else $error("Overflow flag not set at wrap.");

  property p_step;
    s_step |=> count_r == $past(count_r) + 16'h0001;
  endproperty
  a_step: assert property (p_step)
    else $error("Counter did not advance by one on a tick.");

  property p_halt;
    tsc_r.counter_halt && !trst_wr |=> $stable(count_r);
  endproperty
  a_halt: assert property (p_halt)
    else $error("Counter moved while halted.");

  property p_presc;
    tick && tsc_r.prescale_select != 3'h0 && tsc_r.prescale_select != PS_EXT && !wr_en
      |=> !tick;
  endproperty
  a_presc: assert property (p_presc)
    else $error("Divided rate ticked on two cycles in a row.");

  property p_read_cnt;
    s_rd_cnth |-> prdata_r == {24'h00_0000, $past(count_r[15:8])};
  endproperty
  a_read_cnt: assert property (p_read_cnt)
    else $error("Counter high byte read wrong.");

  property p_read_quiet;
    rd_phase && !pwrite && !tick && !trst_wr |=> $stable(count_r);
  endproperty
  a_read_quiet: assert property (p_read_quiet)
    else $error("Read disturbed the counter.");

  property p_ch1_bit5;
    rd_phase && !pwrite && idx == IDX_CH1SC |=> prdata_r[5] == 1'b0;
  endproperty
  a_ch1_bit5: assert property (p_ch1_bit5)
    else $error("Channel 1 bit 5 did not read zero.");

  property p_cap_val0;
    cap_pulse[0] |=> chan_val_r[0] == $past(count_r) && chan_ctl_r[0].chan_flag;
  endproperty
  a_cap_val0: assert property (p_cap_val0)
    else $error("Channel 0 capture did not store the count and flag.");

  property p_cap_val1;
    cap_pulse[1] |=> chan_val_r[1] == $past(count_r) && chan_ctl_r[1].chan_flag;
  endproperty
  a_cap_val1: assert property (p_cap_val1)
    else $error("Channel 1 capture did not store the count and flag.");

  property p_link;
    chan_ctl_r[0].mode_sel_b |-> !cap_pulse[1];
  endproperty
  a_link: assert property (p_link)
    else $error("Channel 1 captured while linked.");

  property p_irq;
    chan_ctl_r[0].chan_flag && chan_ctl_r[0].chan_irq_enable |=> timer_irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("Channel 0 interrupt not raised.");

  property p_unmapped;
    rd_phase && !mapped |=> pready_r && pslverr_r;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("Unmapped access not answered with an error.");

endmodule
